/* File: shared/ser_pkg.sv */
`default_nettype none
package ser_pkg;

    // ------------------------------------------------------------------
    // Register set
    // ------------------------------------------------------------------
    localparam int unsigned NUM_REGS = 11;
    localparam int unsigned REG_W    = 16;
    localparam int unsigned SEL_W    = 4;

    localparam logic [3:0] REG_DEVICE   = 4'h0;
    localparam logic [3:0] REG_OPER     = 4'h1;
    localparam logic [3:0] REG_OPER_CAL = 4'h2;
    localparam logic [3:0] REG_OPER_LLF = 4'h3;
    localparam logic [3:0] REG_OPER_MEA = 4'h4;
    localparam logic [3:0] REG_OPER_SEN = 4'h5;
    localparam logic [3:0] REG_OPER_TRG = 4'h6;
    localparam logic [3:0] REG_OPER_ULF = 4'h7;
    localparam logic [3:0] REG_QUAL     = 4'h8;
    localparam logic [3:0] REG_QUAL_CAL = 4'h9;
    localparam logic [3:0] REG_QUAL_POW = 4'ha;

    // ------------------------------------------------------------------
    // Summary bit positions in the parent condition words
    // ------------------------------------------------------------------
    localparam int unsigned BIT_OPER_CAL = 0;
    localparam int unsigned BIT_OPER_MEA = 4;
    localparam int unsigned BIT_OPER_TRG = 5;
    localparam int unsigned BIT_OPER_SEN = 10;
    localparam int unsigned BIT_OPER_LLF = 11;
    localparam int unsigned BIT_OPER_ULF = 12;
    localparam int unsigned BIT_QUAL_POW = 3;
    localparam int unsigned BIT_QUAL_CAL = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_ENABLE  = 16'h0000;
    localparam logic [15:0] RST_FALLING = 16'h0000;
    localparam logic [15:0] RST_RISING  = 16'hffff;
    localparam logic [15:0] RST_ZERO    = 16'h0000;

    // ------------------------------------------------------------------
    // Error queue
    // ------------------------------------------------------------------
    localparam int unsigned ERRQ_DEPTH = 8;
    localparam int unsigned ERRQ_AW    = 3;
    localparam logic signed [15:0] ERR_NONE = 16'sh0000;

    // ------------------------------------------------------------------
    // Command access kinds
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SER_CMD_RD_COND,
        SER_CMD_RD_EVENT,
        SER_CMD_WR_ENABLE,
        SER_CMD_WR_FALLING,
        SER_CMD_WR_RISING,
        SER_CMD_RD_ENABLE
    } ser_cmd_t;

endpackage
`default_nettype wire

/* File: src/ser_err_queue.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Error queue, newest entry popped first.
// ----------------------------------------------------------------------
module ser_err_queue (
    input  wire logic               clk_sys_in,
    input  wire logic               rst_in,
    input  wire logic               push_in,
    input  wire logic signed [15:0] push_code_in,
    input  wire logic               pop_in,
    output logic signed      [15:0] top_out,
    output logic             [3:0]  count_out
);

    logic signed [15:0] mem_r [ser_pkg::ERRQ_DEPTH];
    logic signed [15:0] mem_nxt [ser_pkg::ERRQ_DEPTH];
    logic [3:0]         cnt_r;
    logic [3:0]         cnt_nxt;
    logic [3:0]         top_idx;
    logic               do_pop;

    // A push into a full queue drops the new entry, since the
    // oldest ones usually carry the root cause.
    always_comb begin
        mem_nxt = mem_r;
        cnt_nxt = cnt_r;
        do_pop  = pop_in && (cnt_r != 4'h0);
        top_idx = cnt_r - 4'h1;
        if (do_pop) begin
            cnt_nxt = cnt_r - 4'h1;
        end
        if (push_in && (cnt_nxt != 4'(ser_pkg::ERRQ_DEPTH))) begin
            mem_nxt[cnt_nxt[ser_pkg::ERRQ_AW-1:0]] = push_code_in;
            cnt_nxt = cnt_nxt + 4'h1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= 4'h0;
            for (int i = 0; i < ser_pkg::ERRQ_DEPTH; i++) begin
                mem_r[i] <= ser_pkg::ERR_NONE;
            end
        end else begin
            cnt_r <= cnt_nxt;
            mem_r <= mem_nxt;
        end
    end

    assign top_out   = (cnt_r == 4'h0) ? ser_pkg::ERR_NONE
                                       : mem_r[top_idx[ser_pkg::ERRQ_AW-1:0]];
    assign count_out = cnt_r;

endmodule

`default_nettype wire

/* File: src/ser_stat_reg.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// One status register: condition, two filters, event latch, enable.
// ----------------------------------------------------------------------
module ser_stat_reg (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic [15:0] cond_in,
    input  wire logic        preset_in,
    input  wire logic        ev_clr_in,
    input  wire logic        wr_en_in,
    input  wire logic        wr_fall_in,
    input  wire logic        wr_rise_in,
    input  wire logic [15:0] wr_data_in,
    output logic      [15:0] cond_out,
    output logic      [15:0] event_out,
    output logic      [15:0] enable_out,
    output logic      [15:0] rising_filter_out,
    output logic      [15:0] falling_filter_out,
    output logic             summary_out
);

    logic [15:0] cond_r;
    logic [15:0] event_r;
    logic [15:0] event_nxt;
    logic [15:0] enable_r;
    logic [15:0] enable_nxt;
    logic [15:0] rise_r;
    logic [15:0] rise_nxt;
    logic [15:0] fall_r;
    logic [15:0] fall_nxt;
    logic        summary_r;
    logic        summary_nxt;
    logic [15:0] hit;

    always_comb begin
        hit = (rise_r & cond_in & ~cond_r)
            | (fall_r & ~cond_in & cond_r);
        // A new edge in the clearing cycle survives the clear.
        event_nxt = (ev_clr_in ? ser_pkg::RST_ZERO : event_r) | hit;
        enable_nxt = wr_en_in ? wr_data_in : enable_r;
        rise_nxt   = wr_rise_in ? wr_data_in : rise_r;
        fall_nxt   = wr_fall_in ? wr_data_in : fall_r;
        if (preset_in) begin
            enable_nxt = ser_pkg::RST_ENABLE;
            rise_nxt   = ser_pkg::RST_RISING;
            fall_nxt   = ser_pkg::RST_FALLING;
        end
        summary_nxt = |(event_r & enable_r);
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cond_r    <= ser_pkg::RST_ZERO;
            event_r   <= ser_pkg::RST_ZERO;
            enable_r  <= ser_pkg::RST_ENABLE;
            rise_r    <= ser_pkg::RST_RISING;
            fall_r    <= ser_pkg::RST_FALLING;
            summary_r <= 1'b0;
        end else begin
            cond_r    <= cond_in;
            event_r   <= event_nxt;
            enable_r  <= enable_nxt;
            rise_r    <= rise_nxt;
            fall_r    <= fall_nxt;
            summary_r <= summary_nxt;
        end
    end

    assign cond_out           = cond_r;
    assign event_out          = event_r;
    assign enable_out         = enable_r;
    assign rising_filter_out  = rise_r;
    assign falling_filter_out = fall_r;
    assign summary_out        = summary_r;

endmodule

`default_nettype wire

/* File: src/ser_status_event_reporting.sv */
`timescale 1ns/100ps
`default_nettype none

// Function
// - Preset restores filters and enables at once.
// - Error pop returns newest entry, removes it.
// - Error codes signed; positive module, negative standard.
// - Empty queue pops zero, queue unchanged.
// - Condition reads never alter condition bits.
// - Event reads return latched bits, then clear.
// - Enabled event raises parent summary; enable resets 0.
// - Falling filter latches one-to-zero changes; resets 0.
// - Rising filter latches zero-to-one changes; resets ones.
// - Device, operating, quality groups with subgroups.

module ser_status_event_reporting (
    input  wire logic               clk_sys_in,
    input  wire logic               rst_in,
    input  wire logic [15:0]        dev_cond_in,
    input  wire logic [15:0]        oper_cond_in,
    input  wire logic [15:0]        oper_cal_cond_in,
    input  wire logic [15:0]        oper_llf_cond_in,
    input  wire logic [15:0]        oper_mea_cond_in,
    input  wire logic [15:0]        oper_sen_cond_in,
    input  wire logic [15:0]        oper_trg_cond_in,
    input  wire logic [15:0]        oper_ulf_cond_in,
    input  wire logic [15:0]        qual_cond_in,
    input  wire logic [15:0]        qual_cal_cond_in,
    input  wire logic [15:0]        qual_pow_cond_in,
    input  wire logic               err_push_in,
    input  wire logic signed [15:0] err_code_in,
    input  wire logic               cmd_valid_in,
    input  wire logic [2:0]         cmd_kind_in,
    input  wire logic [3:0]         cmd_sel_in,
    input  wire logic [15:0]        cmd_data_in,
    input  wire logic               preset_in,
    input  wire logic               err_pop_in,
    output logic                    rsp_valid_out,
    output logic [15:0]             rsp_data_out,
    output logic                    oper_summary_out,
    output logic                    qual_summary_out,
    output logic                    dev_summary_out,
    output logic [3:0]              err_count_out
);

    // ------------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------------
    logic [15:0] cond_w  [ser_pkg::NUM_REGS];
    logic [15:0] cond_q  [ser_pkg::NUM_REGS];
    logic [15:0] event_q [ser_pkg::NUM_REGS];
    logic [15:0] en_q    [ser_pkg::NUM_REGS];
    logic        sum_q   [ser_pkg::NUM_REGS];
    logic [15:0] oper_cond_mix;
    logic [15:0] qual_cond_mix;
    ser_pkg::ser_cmd_t kind;

    assign kind = ser_pkg::ser_cmd_t'(cmd_kind_in);

    function automatic logic hit_sel(input logic v, input logic [3:0] s, input int unsigned idx);
        hit_sel = v && (s == 4'(idx));
    endfunction

    // Subgroup summaries are folded into the parent condition word.
    always_comb begin
        oper_cond_mix = oper_cond_in;
        oper_cond_mix[ser_pkg::BIT_OPER_CAL] = sum_q[ser_pkg::REG_OPER_CAL];
        oper_cond_mix[ser_pkg::BIT_OPER_MEA] = sum_q[ser_pkg::REG_OPER_MEA];
        oper_cond_mix[ser_pkg::BIT_OPER_TRG] = sum_q[ser_pkg::REG_OPER_TRG];
        oper_cond_mix[ser_pkg::BIT_OPER_SEN] = sum_q[ser_pkg::REG_OPER_SEN];
        oper_cond_mix[ser_pkg::BIT_OPER_LLF] = sum_q[ser_pkg::REG_OPER_LLF];
        oper_cond_mix[ser_pkg::BIT_OPER_ULF] = sum_q[ser_pkg::REG_OPER_ULF];
        qual_cond_mix = qual_cond_in;
        qual_cond_mix[ser_pkg::BIT_QUAL_POW] = sum_q[ser_pkg::REG_QUAL_POW];
        qual_cond_mix[ser_pkg::BIT_QUAL_CAL] = sum_q[ser_pkg::REG_QUAL_CAL];
    end

    // Condition inputs are from same-clock measurement logic.
    assign cond_w[ser_pkg::REG_DEVICE]   = dev_cond_in;
    assign cond_w[ser_pkg::REG_OPER]     = oper_cond_mix;
    assign cond_w[ser_pkg::REG_OPER_CAL] = oper_cal_cond_in;
    assign cond_w[ser_pkg::REG_OPER_LLF] = oper_llf_cond_in;
    assign cond_w[ser_pkg::REG_OPER_MEA] = oper_mea_cond_in;
    assign cond_w[ser_pkg::REG_OPER_SEN] = oper_sen_cond_in;
    assign cond_w[ser_pkg::REG_OPER_TRG] = oper_trg_cond_in;
    assign cond_w[ser_pkg::REG_OPER_ULF] = oper_ulf_cond_in;
    assign cond_w[ser_pkg::REG_QUAL]     = qual_cond_mix;
    assign cond_w[ser_pkg::REG_QUAL_CAL] = qual_cal_cond_in;
    assign cond_w[ser_pkg::REG_QUAL_POW] = qual_pow_cond_in;

    for (genvar g = 0; g < ser_pkg::NUM_REGS; g++) begin : g_reg
        ser_stat_reg u_reg (
            .clk_sys_in         (clk_sys_in),
            .rst_in             (rst_in),
            .cond_in            (cond_w[g]),
            .preset_in          (preset_in),
            .ev_clr_in          (hit_sel(cmd_valid_in && kind == ser_pkg::SER_CMD_RD_EVENT,
                                         cmd_sel_in, g)),
            .wr_en_in           (hit_sel(cmd_valid_in && kind == ser_pkg::SER_CMD_WR_ENABLE,
                                         cmd_sel_in, g)),
            .wr_fall_in         (hit_sel(cmd_valid_in && kind == ser_pkg::SER_CMD_WR_FALLING,
                                         cmd_sel_in, g)),
            .wr_rise_in         (hit_sel(cmd_valid_in && kind == ser_pkg::SER_CMD_WR_RISING,
                                         cmd_sel_in, g)),
            .wr_data_in         (cmd_data_in),
            .cond_out           (cond_q[g]),
            .event_out          (event_q[g]),
            .enable_out         (en_q[g]),
            .rising_filter_out  (),
            .falling_filter_out (),
            .summary_out        (sum_q[g])
        );
    end

    // ------------------------------------------------------------------
    // Error queue
    // ------------------------------------------------------------------
    logic signed [15:0] err_top;
    logic [3:0]         err_cnt;

    ser_err_queue u_errq (
        .clk_sys_in   (clk_sys_in),
        .rst_in       (rst_in),
        .push_in      (err_push_in),
        .push_code_in (err_code_in),
        .pop_in       (err_pop_in),
        .top_out      (err_top),
        .count_out    (err_cnt)
    );

    // ------------------------------------------------------------------
    // Response path
    // ------------------------------------------------------------------
    logic        rsp_valid_r;
    logic        rsp_valid_nxt;
    logic [15:0] rsp_data_r;
    logic [15:0] rsp_data_nxt;
    logic        oper_sum_r;
    logic        qual_sum_r;
    logic        dev_sum_r;
    logic [3:0]  err_cnt_r;
    logic        sel_ok;

    // A pop takes priority over a register read in the same cycle.
    // Reads of the event part show the value before clearing.
    always_comb begin
        sel_ok        = cmd_sel_in < 4'(ser_pkg::NUM_REGS);
        rsp_valid_nxt = err_pop_in;
        rsp_data_nxt  = ser_pkg::RST_ZERO;
        if (err_pop_in) begin
            rsp_data_nxt = err_top;
        end else if (cmd_valid_in && sel_ok) begin
            unique case (kind)
                ser_pkg::SER_CMD_RD_COND: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = cond_q[cmd_sel_in];
                end
                ser_pkg::SER_CMD_RD_EVENT: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = event_q[cmd_sel_in];
                end
                ser_pkg::SER_CMD_RD_ENABLE: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt  = en_q[cmd_sel_in];
                end
                default: begin
                    rsp_valid_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r  <= ser_pkg::RST_ZERO;
            oper_sum_r  <= 1'b0;
            qual_sum_r  <= 1'b0;
            dev_sum_r   <= 1'b0;
            err_cnt_r   <= 4'h0;
        end else begin
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r  <= rsp_data_nxt;
            oper_sum_r  <= sum_q[ser_pkg::REG_OPER];
            qual_sum_r  <= sum_q[ser_pkg::REG_QUAL];
            dev_sum_r   <= sum_q[ser_pkg::REG_DEVICE];
            err_cnt_r   <= err_cnt;
        end
    end

    assign rsp_valid_out    = rsp_valid_r;
    assign rsp_data_out     = rsp_data_r;
    assign oper_summary_out = oper_sum_r;
    assign qual_summary_out = qual_sum_r;
    assign dev_summary_out  = dev_sum_r;
    assign err_count_out    = err_cnt_r;

endmodule

`default_nettype wire

/* File: verification/ser_host.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Remote host issuing one status command at a time
// ----------------------------------------------------------------------
module ser_host (
    input  wire logic        clk_sys_in,
    input  wire logic        rsp_valid_in,
    input  wire logic [15:0] rsp_data_in,
    output logic             cmd_valid_out,
    output logic [2:0]       cmd_kind_out,
    output logic [3:0]       cmd_sel_out,
    output logic [15:0]      cmd_data_out,
    output logic             preset_out,
    output logic             err_pop_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_kind_out  = 3'h0;
        cmd_sel_out   = 4'h0;
        cmd_data_out  = 16'h0000;
        preset_out    = 1'b0;
        err_pop_out   = 1'b0;
    end

    // Event reads are issued only when the caller means to consume them.
    // After release the qualifiers drop to 0 and kind, select and data are inverted so stale values never look valid.
    task automatic issue(input logic [2:0] kind, input logic [3:0] sel, input logic [15:0] data,
                         input logic pop, input logic pre, output logic vld,
                         output logic [15:0] got);
        @(negedge clk_sys_in);
        cmd_valid_out = ~pop & ~pre;
        err_pop_out   = pop;
        preset_out    = pre;
        cmd_kind_out  = kind;
        cmd_sel_out   = sel;
        cmd_data_out  = data;
        @(negedge clk_sys_in);
        cmd_valid_out = 1'b0;
        err_pop_out   = 1'b0;
        preset_out    = 1'b0;
        cmd_kind_out  = ~kind;
        cmd_sel_out   = ~sel;
        cmd_data_out  = ~data;
        vld           = rsp_valid_in;
        got           = rsp_data_in;
    endtask
endmodule

`default_nettype wire

/* File: verification/ser_status_event_reporting_monitor.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Port checks of the status and error reporting block
// ----------------------------------------------------------------------
module ser_status_event_reporting_monitor (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic [15:0] dev_cond_in,
    input  wire logic        err_push_in,
    input  wire logic        cmd_valid_in,
    input  wire logic [2:0]  cmd_kind_in,
    input  wire logic [3:0]  cmd_sel_in,
    input  wire logic        preset_in,
    input  wire logic        err_pop_in,
    input  wire logic        rsp_valid_out,
    input  wire logic [15:0] rsp_data_out,
    input  wire logic        oper_summary_out,
    input  wire logic        qual_summary_out,
    input  wire logic        dev_summary_out,
    input  wire logic [3:0]  err_count_out
);
    logic rd_ok;
    logic ev_rd;
    logic en_wr;
    assign rd_ok = cmd_valid_in && cmd_sel_in < 4'hb
                   && (cmd_kind_in == 3'h0 || cmd_kind_in == 3'h1 || cmd_kind_in == 3'h5);
    assign ev_rd = cmd_valid_in && !err_pop_in && cmd_kind_in == 3'h1 && cmd_sel_in == 4'h0;
    assign en_wr = cmd_valid_in && cmd_kind_in == 3'h2;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    property p_rd_answer;
        rd_ok |=> rsp_valid_out;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read gave no response");
    property p_no_answer;
        cmd_valid_in && !err_pop_in && !rd_ok |=> !rsp_valid_out;
    endproperty
    a_no_answer: assert property (p_no_answer)
        else $error("write or unmapped select gave a response");
    property p_rsp_cause;
        rsp_valid_out |-> $past(rd_ok) || $past(err_pop_in);
    endproperty
    a_rsp_cause: assert property (p_rsp_cause)
        else $error("response without a request");
    property p_pop_answer;
        err_pop_in |=> rsp_valid_out;
    endproperty
    a_pop_answer: assert property (p_pop_answer)
        else $error("pop gave no response");
    property p_pop_empty;
        err_pop_in && !err_push_in && !$past(err_push_in) && err_count_out == 4'h0
            |=> rsp_data_out == 16'h0000;
    endproperty
    a_pop_empty: assert property (p_pop_empty)
        else $error("empty pop did not return zero");
    property p_pop_dec;
        err_pop_in && !err_push_in && !$past(err_push_in) && !$past(err_pop_in)
            && err_count_out != 4'h0 |=> ##1 err_count_out == $past(err_count_out, 2) - 4'h1;
    endproperty
    a_pop_dec: assert property (p_pop_dec)
        else $error("pop did not remove one entry");
    property p_cond_read;
        cmd_valid_in && !err_pop_in && cmd_kind_in == 3'h0 && cmd_sel_in == 4'h0
            && $stable(dev_cond_in) |=> rsp_data_out == $past(dev_cond_in);
    endproperty
    a_cond_read: assert property (p_cond_read)
        else $error("condition read returned wrong word");
    property p_ev_clear;
        (ev_rd && $stable(dev_cond_in)) ##1 $stable(dev_cond_in) ##1 (ev_rd && $stable(dev_cond_in))
            |=> rsp_data_out == 16'h0000;
    endproperty
    a_ev_clear: assert property (p_ev_clear)
        else $error("event part not cleared by read");
    property p_preset_quiet;
        preset_in ##1 (!en_wr)[*3] |=> !dev_summary_out && !oper_summary_out && !qual_summary_out;
    endproperty
    a_preset_quiet: assert property (p_preset_quiet)
        else $error("summary still set after preset");

    c_pop_empty: cover property (err_pop_in && err_count_out == 4'h0);
    c_ev_clear: cover property (p_ev_clear);
    c_oper_sum: cover property (oper_summary_out && qual_summary_out == 1'b0);
endmodule

bind ser_status_event_reporting ser_status_event_reporting_monitor u_mon (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .dev_cond_in(dev_cond_in),
    .err_push_in(err_push_in), .cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in),
    .cmd_sel_in(cmd_sel_in), .preset_in(preset_in), .err_pop_in(err_pop_in),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .oper_summary_out(oper_summary_out), .qual_summary_out(qual_summary_out),
    .dev_summary_out(dev_summary_out), .err_count_out(err_count_out)
);

`default_nettype wire

/* File: verification/ser_status_event_reporting_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module ser_status_event_reporting_tb;
    logic                 clk_sys_in = 1'b0;
    logic                 rst_in = 1'b1;
    logic [15:0]          cond [11];
    logic                 err_push_in = 1'b0;
    logic signed [15:0]   err_code_in = 16'sh0000;
    logic                 cmd_valid, preset, err_pop, rsp_valid, vld;
    logic                 oper_sum, qual_sum, dev_sum;
    logic [2:0]           cmd_kind;
    logic [3:0]           cmd_sel, err_count;
    logic [15:0]          cmd_data, rsp_data, got;
    int                   n_fail = 0;
    int                   checks = 0;

    always #20 clk_sys_in = ~clk_sys_in;

    ser_status_event_reporting dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .dev_cond_in(cond[0]), .oper_cond_in(cond[1]),
        .oper_cal_cond_in(cond[2]), .oper_llf_cond_in(cond[3]), .oper_mea_cond_in(cond[4]),
        .oper_sen_cond_in(cond[5]), .oper_trg_cond_in(cond[6]), .oper_ulf_cond_in(cond[7]),
        .qual_cond_in(cond[8]), .qual_cal_cond_in(cond[9]), .qual_pow_cond_in(cond[10]),
        .err_push_in(err_push_in), .err_code_in(err_code_in), .cmd_valid_in(cmd_valid),
        .cmd_kind_in(cmd_kind), .cmd_sel_in(cmd_sel), .cmd_data_in(cmd_data),
        .preset_in(preset), .err_pop_in(err_pop), .rsp_valid_out(rsp_valid),
        .rsp_data_out(rsp_data), .oper_summary_out(oper_sum), .qual_summary_out(qual_sum),
        .dev_summary_out(dev_sum), .err_count_out(err_count));

    ser_host u_host (
        .clk_sys_in(clk_sys_in), .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data),
        .cmd_valid_out(cmd_valid), .cmd_kind_out(cmd_kind), .cmd_sel_out(cmd_sel),
        .cmd_data_out(cmd_data), .preset_out(preset), .err_pop_out(err_pop));

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_word({15'h0000, g}, {15'h0000, e});
    endtask
    task automatic rd(input logic [2:0] k, input logic [3:0] s, input logic [15:0] e);
        u_host.issue(k, s, 16'h0000, 1'b0, 1'b0, vld, got);
        chk_bit(vld, 1'b1);
        chk_word(got, e);
    endtask
    task automatic wr(input logic [2:0] k, input logic [3:0] s, input logic [15:0] d);
        u_host.issue(k, s, d, 1'b0, 1'b0, vld, got);
        chk_bit(vld, 1'b0);
    endtask
    task automatic pop(input logic [15:0] e);
        u_host.issue(3'h0, 4'h0, 16'h0000, 1'b1, 1'b0, vld, got);
        chk_bit(vld, 1'b1);
        chk_word(got, e);
    endtask
    task automatic push(input logic [15:0] v);
        @(negedge clk_sys_in);
        err_push_in = 1'b1;
        err_code_in = v;
        @(negedge clk_sys_in);
        err_push_in = 1'b0;
        err_code_in = ~v;
    endtask
    task automatic set_cond(input int s, input logic [15:0] v);
        @(negedge clk_sys_in);
        cond[s] = v;
    endtask
    // Subgroup summary must climb into the parent word and its output.
    task automatic chain(input logic [3:0] sub, input logic [3:0] par, input int b, input int q);
        wr(3'h2, sub, 16'h0001);
        wr(3'h2, par, 16'h0001 << b);
        set_cond(sub, 16'h0001);
        repeat (8) @(negedge clk_sys_in);
        chk_bit(q ? qual_sum : oper_sum, 1'b1);
        rd(3'h0, par, 16'h0001 << b);
        rd(3'h1, sub, 16'h0001);
        rd(3'h1, par, 16'h0001 << b);
        set_cond(sub, 16'h0000);
        repeat (8) @(negedge clk_sys_in);
        chk_bit(q ? qual_sum : oper_sum, 1'b0);
    endtask
    task automatic print_verdict;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        for (int i = 0; i < 11; i++) begin
            cond[i] = 16'h0000;
        end
        repeat (8) @(negedge clk_sys_in);
        rst_in = 1'b0;
        for (int s = 0; s < 11; s++) begin
            rd(3'h5, 4'(s), 16'h0000);
            rd(3'h1, 4'(s), 16'h0000);
            set_cond(s, 16'h0042);
            rd(3'h0, 4'(s), 16'h0042);
            rd(3'h0, 4'(s), 16'h0042);
            rd(3'h1, 4'(s), 16'h0042);
            rd(3'h1, 4'(s), 16'h0000);
            set_cond(s, 16'h0000);
            rd(3'h1, 4'(s), 16'h0000);
            wr(3'h3, 4'(s), 16'h0002);
            wr(3'h4, 4'(s), 16'h0000);
            wr(3'h2, 4'(s), 16'h00a0);
            rd(3'h5, 4'(s), 16'h00a0);
            set_cond(s, 16'h0042);
            rd(3'h1, 4'(s), 16'h0000);
            set_cond(s, 16'h0000);
            rd(3'h1, 4'(s), 16'h0002);
            u_host.issue(3'h0, 4'h0, 16'h0000, 1'b0, 1'b1, vld, got);
            rd(3'h5, 4'(s), 16'h0000);
            set_cond(s, 16'h0042);
            rd(3'h1, 4'(s), 16'h0042);
            set_cond(s, 16'h0000);
            rd(3'h1, 4'(s), 16'h0000);
        end
        wr(3'h0, 4'hb, 16'h0000);
        $display("test filters done");
        wr(3'h2, ser_pkg::REG_DEVICE, 16'h0002);
        set_cond(0, 16'h0002);
        repeat (3) @(negedge clk_sys_in);
        chk_bit(dev_sum, 1'b1);
        rd(3'h1, ser_pkg::REG_DEVICE, 16'h0002);
        repeat (3) @(negedge clk_sys_in);
        chk_bit(dev_sum, 1'b0);
        set_cond(0, 16'h0000);
        chain(ser_pkg::REG_OPER_MEA, ser_pkg::REG_OPER, ser_pkg::BIT_OPER_MEA, 0);
        chain(ser_pkg::REG_QUAL_POW, ser_pkg::REG_QUAL, ser_pkg::BIT_QUAL_POW, 1);
        $display("test summaries done");
        pop(16'h0000);
        push(16'hfffb);
        push(16'h0007);
        pop(16'h0007);
        pop(16'hfffb);
        pop(16'h0000);
        for (int k = 1; k < 10; k++) begin
            push(16'(k));
        end
        repeat (2) @(negedge clk_sys_in);
        chk_word({12'h000, err_count}, 16'h0008);
        for (int k = 8; k > 0; k--) begin
            pop(16'(k));
        end
        repeat (2) @(negedge clk_sys_in);
        chk_word({12'h000, err_count}, 16'h0000);
        $display("test error queue done");
        print_verdict();
    end

    // Tests need about 570 cycles; the guard allows twenty thousand.
    initial begin
        #(40 * 20000);
        n_fail++;
        print_verdict();
    end
endmodule

`default_nettype wire
